// ### src/pirc_pkg.sv
// constants shared by the two-level interrupt controller
// assumes an 8-bit register port and same-clock event sources
// Functional notes
// - source zero is always high priority
// - priority mode vectors: high 0008h, low 0018h
// - high request preempts running low service
// - nineteen software registers control interrupts
// - each source has flag, enable, priority
// - priority bits ignored while priority mode off
// - compat: peripherals need both global enables
// - compat: global enable gates every source
// - compat: every interrupt vectors to 0008h
// - priority enable bit renames both global enables
// - high enable permits all high-priority sources
// - high enable clear blocks every source
// - low enable clear blocks only low sources
// - low sources need both level enables
// - flag, enable, level enable vector immediately
// - clearing one enable stops only that source
// - response clears the level's global enable
// - no low request served during high service
// - return instruction sets level enable again
// - flags set regardless of any enable
package pirc_pkg;
    localparam int          PIRC_NGRP      = 5;        // flag, enable and priority registers per kind
    localparam logic [7:0]  PIRC_ADDR_CTL0 = 8'h00;    // main interrupt control register
    localparam logic [7:0]  PIRC_ADDR_CTL1 = 8'h01;    // second general control register
    localparam logic [7:0]  PIRC_ADDR_CTL2 = 8'h02;    // third general control register
    localparam logic [7:0]  PIRC_ADDR_FLAG = 8'h03;    // first of five flag registers
    localparam logic [7:0]  PIRC_ADDR_EN   = 8'h08;    // first of five enable registers
    localparam logic [7:0]  PIRC_ADDR_PRIO = 8'h0d;    // first of five priority registers
    localparam logic [7:0]  PIRC_ADDR_RESET_CONTROL_REGISTER = 8'h12;    // reset control register
    localparam logic [7:0]  PIRC_ADDR_STAT = 8'h13;    // read-only service status
    localparam int          PIRC_BIT_GHE   = 7;        // global_or_high_level_enable
    localparam int          PIRC_BIT_PLE   = 6;        // peripheral_or_low_level_enable
    localparam int          PIRC_BIT_PME   = 7;        // priority_mode_enable in reset control
    localparam logic [7:0]  PIRC_RST_CTL   = 8'h00;
    localparam logic [7:0]  PIRC_RST_FLAG  = 8'h00;
    localparam logic [7:0]  PIRC_RST_EN    = 8'h00;
    localparam logic [7:0]  PIRC_RST_PRIO  = 8'hff;
    localparam logic [7:0]  PIRC_RST_RESET_CONTROL_REGISTER  = 8'h00;
    localparam logic [15:0] PIRC_VEC_HIGH  = 16'h0008;
    localparam logic [15:0] PIRC_VEC_LOW   = 16'h0018;
    typedef enum logic [1:0] {
        PIRC_SVC_NONE = 2'b00,
        PIRC_SVC_LOW  = 2'b01,
        PIRC_SVC_HIGH = 2'b10,
        PIRC_SVC_BOTH = 2'b11   // high service nested over low
    } pirc_svc_t;
endpackage : pirc_pkg

// ### src/pirc_core.sv
// two-level priority interrupt controller, register file and core handshake
// assumes events and core strobes come from logic on sys_clk
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module pirc_core import pirc_pkg::*; #(
    parameter int          NSRC        = 40,               // eight sources per flag register
    parameter logic [39:0] PERIPH_MASK = 40'hff_ffff_ff00  // sources gated by the peripheral enable
) (
    input  wire logic             sys_clk,      // core clock
    input  wire logic             rstn,         // async reset, active low
    input  wire logic [7:0]       reg_addr,     // register index
    input  wire logic [7:0]       reg_wdata,    // write data
    input  wire logic             reg_wr,       // write strobe
    input  wire logic             reg_rd,       // read strobe
    output logic      [7:0]       reg_rdata,    // read data, cycle after strobe
    input  wire logic [NSRC-1:0]  src_event,    // one-cycle event pulses
    input  wire logic             core_ack,     // core takes the pending interrupt
    input  wire logic             core_return_from_interrupt_instruction,  // return-from-interrupt executed
    output logic                  irq_req,      // interrupt pending to core
    output logic                  irq_hi,       // pending request is high level
    output logic      [15:0]      irq_vector    // branch address
);
    logic [23:0]     ctl_reg,  ctl_next;
    logic [NSRC-1:0] flag_reg, flag_next;
    logic [NSRC-1:0] en_reg,   en_next;
    logic [NSRC-1:0] prio_reg, prio_next;
    logic [7:0]      reset_control_register_reg, reset_control_register_next;
    logic [7:0]      rdata_reg, rdata_next;
    logic            req_reg,  req_next;
    logic            hi_reg,   hi_next;
    logic [15:0]     vec_reg,  vec_next;
    pirc_svc_t       svc_reg,  svc_next;
    logic            ghe, ple, pme, ack_take;
    logic [NSRC-1:0] fe, prio_eff;
    logic            pend_hi, pend_lo;

    // effective enables and pending levels
    assign ghe      = ctl_reg[PIRC_BIT_GHE];
    assign ple      = ctl_reg[PIRC_BIT_PLE];
    assign pme      = reset_control_register_reg[PIRC_BIT_PME];
    assign fe       = flag_reg & en_reg;
    assign prio_eff = prio_reg | {{(NSRC-1){1'b0}}, 1'b1};
    assign ack_take = core_ack & req_reg;
    always_comb begin
        if (pme) begin
            pend_hi = ghe & (|(fe & prio_eff));
            // a high service in progress holds off low requests
            pend_lo = ghe & ple & (|(fe & ~prio_eff))
                      & ~svc_reg[1];
        end else begin
            // priority bits play no part here
            pend_hi = ghe & ((|(fe & ~PERIPH_MASK[NSRC-1:0]))
                      | (ple & (|(fe & PERIPH_MASK[NSRC-1:0]))));
            pend_lo = 1'b0;
        end
    end

    // register writes, hardware flag sets and the response sequence
    always_comb begin
        ctl_next   = ctl_reg;
        flag_next  = flag_reg;
        en_next    = en_reg;
        prio_next  = prio_reg;
        reset_control_register_next  = reset_control_register_reg;
        svc_next   = svc_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            if (reg_addr == PIRC_ADDR_CTL0) ctl_next[7:0] = reg_wdata;
            if (reg_addr == PIRC_ADDR_CTL1) ctl_next[15:8] = reg_wdata;
            if (reg_addr == PIRC_ADDR_CTL2) ctl_next[23:16] = reg_wdata;
            if (reg_addr == PIRC_ADDR_RESET_CONTROL_REGISTER) reset_control_register_next = reg_wdata;
            for (int g = 0; g < PIRC_NGRP; g++) begin
                if (reg_addr == PIRC_ADDR_FLAG + 8'(g)) flag_next[g*8 +: 8] = reg_wdata;
                if (reg_addr == PIRC_ADDR_EN + 8'(g)) en_next[g*8 +: 8] = reg_wdata;
                if (reg_addr == PIRC_ADDR_PRIO + 8'(g)) prio_next[g*8 +: 8] = reg_wdata;
            end
        end
        // an event in the clearing cycle still sets its flag
        flag_next = flag_next | src_event;
        if (reg_rd) begin
            if (reg_addr == PIRC_ADDR_CTL0) rdata_next = ctl_reg[7:0];
            if (reg_addr == PIRC_ADDR_CTL1) rdata_next = ctl_reg[15:8];
            if (reg_addr == PIRC_ADDR_CTL2) rdata_next = ctl_reg[23:16];
            if (reg_addr == PIRC_ADDR_RESET_CONTROL_REGISTER) rdata_next = reset_control_register_reg;
            if (reg_addr == PIRC_ADDR_STAT) rdata_next = {5'h00, req_reg, svc_reg};
            for (int g = 0; g < PIRC_NGRP; g++) begin
                if (reg_addr == PIRC_ADDR_FLAG + 8'(g)) rdata_next = flag_reg[g*8 +: 8];
                if (reg_addr == PIRC_ADDR_EN + 8'(g)) rdata_next = en_reg[g*8 +: 8];
                if (reg_addr == PIRC_ADDR_PRIO + 8'(g)) rdata_next = prio_reg[g*8 +: 8];
            end
        end
        // hardware response overrides a same-cycle software write
        if (ack_take) begin
            if (hi_reg) begin
                ctl_next[PIRC_BIT_GHE] = 1'b0;
                svc_next = (svc_reg == PIRC_SVC_LOW) ? PIRC_SVC_BOTH : PIRC_SVC_HIGH;
            end else begin
                ctl_next[PIRC_BIT_PLE] = 1'b0;
                svc_next = PIRC_SVC_LOW;
            end
        end else if (core_return_from_interrupt_instruction) begin
            case (svc_reg)
                PIRC_SVC_BOTH: begin
                    ctl_next[PIRC_BIT_GHE] = 1'b1;
                    svc_next = PIRC_SVC_LOW;
                end
                PIRC_SVC_HIGH: begin
                    ctl_next[PIRC_BIT_GHE] = 1'b1;
                    svc_next = PIRC_SVC_NONE;
                end
                PIRC_SVC_LOW: begin
                    ctl_next[PIRC_BIT_PLE] = 1'b1;
                    svc_next = PIRC_SVC_NONE;
                end
                default: begin
                    ctl_next[PIRC_BIT_GHE] = 1'b1;
                    svc_next = PIRC_SVC_NONE;
                end
            endcase
        end
        // request and vector registered together; dropped on the taking cycle
        req_next = ~ack_take & (pend_hi | pend_lo);
        hi_next  = pend_hi | ~pme;
        vec_next = (pend_hi | ~pme) ? PIRC_VEC_HIGH : PIRC_VEC_LOW;
    end

    // state registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctl_reg   <= {3{PIRC_RST_CTL}};
            flag_reg  <= {PIRC_NGRP{PIRC_RST_FLAG}};
            en_reg    <= {PIRC_NGRP{PIRC_RST_EN}};
            prio_reg  <= {PIRC_NGRP{PIRC_RST_PRIO}};
            reset_control_register_reg  <= PIRC_RST_RESET_CONTROL_REGISTER;
            rdata_reg <= 8'h00;
            req_reg   <= 1'b0;
            hi_reg    <= 1'b1;
            vec_reg   <= PIRC_VEC_HIGH;
            svc_reg   <= PIRC_SVC_NONE;
        end else begin
            ctl_reg   <= ctl_next;
            flag_reg  <= flag_next;
            en_reg    <= en_next;
            prio_reg  <= prio_next;
            reset_control_register_reg  <= reset_control_register_next;
            rdata_reg <= rdata_next;
            req_reg   <= req_next;
            hi_reg    <= hi_next;
            vec_reg   <= vec_next;
            svc_reg   <= svc_next;
        end
    end

    assign reg_rdata  = rdata_reg;
    assign irq_req    = req_reg;
    assign irq_hi     = hi_reg;
    assign irq_vector = vec_reg;

    // checks on vectoring, enables, service state, flags and registers
    property p_compat_vec;
        @(posedge sys_clk) disable iff (!rstn)
        (!pme && !$past(pme) && req_reg) |-> vec_reg == PIRC_VEC_HIGH;
    endproperty
    a_compat_vec: assert property (p_compat_vec) else $error("compat vector not 0008h");

    property p_level_vec;
        @(posedge sys_clk) disable iff (!rstn)
        req_reg |-> (hi_reg ? vec_reg == PIRC_VEC_HIGH : vec_reg == PIRC_VEC_LOW);
    endproperty
    a_level_vec: assert property (p_level_vec) else $error("vector does not match level");

    property p_ack_clears;
        @(posedge sys_clk) disable iff (!rstn)
        (ack_take && hi_reg) |=> !ghe && !req_reg;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("response left enable set");

    property p_return_from_interrupt_instruction_sets;
        @(posedge sys_clk) disable iff (!rstn)
        (core_return_from_interrupt_instruction && !ack_take && svc_reg == PIRC_SVC_HIGH) |=> ghe && svc_reg == PIRC_SVC_NONE;
    endproperty
    a_return_from_interrupt_instruction_sets: assert property (p_return_from_interrupt_instruction_sets) else $error("return did not re-enable");

    property p_no_low_in_high;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && svc_reg[1]) |=> !(req_reg && !hi_reg);
    endproperty
    a_no_low_in_high: assert property (p_no_low_in_high) else $error("low served in high");

    property p_flag_set;
        @(posedge sys_clk) disable iff (!rstn)
        (src_event != '0) |=> (flag_reg & $past(src_event)) == $past(src_event);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event flag lost");

    property p_ghe_blocks;
        @(posedge sys_clk) disable iff (!rstn)
        !ghe |=> !req_reg;
    endproperty
    a_ghe_blocks: assert property (p_ghe_blocks) else $error("request with enable clear");

    property p_src0_high;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && fe[0] && ghe && !ack_take) |=> req_reg && hi_reg;
    endproperty
    a_src0_high: assert property (p_src0_high) else $error("source zero not high");

    property p_en_gate;
        @(posedge sys_clk) disable iff (!rstn)
        (fe == '0) |=> !req_reg;
    endproperty
    a_en_gate: assert property (p_en_gate) else $error("request without enabled flag");

    property p_low_needs_both;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && !ple) |=> !(req_reg && !hi_reg);
    endproperty
    a_low_needs_both: assert property (p_low_needs_both) else $error("low without low enable");

    property p_preempt;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && svc_reg == PIRC_SVC_LOW && ghe && (|(fe & prio_eff)) && !ack_take) |=> req_reg && hi_reg;
    endproperty
    a_preempt: assert property (p_preempt) else $error("high did not preempt low");

    property p_compat_any;
        @(posedge sys_clk) disable iff (!rstn)
        (!pme && ghe && (|(fe & ~PERIPH_MASK[NSRC-1:0])) && !ack_take) |=> req_reg;
    endproperty
    a_compat_any: assert property (p_compat_any) else $error("compat source not requested");

    // read data stands for one cycle only, so a stale byte never looks fresh
    property p_rdata_idle;
        @(posedge sys_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

    // taking a low request closes the low level and drops the request at once
    property p_ack_low;
        @(posedge sys_clk) disable iff (!rstn)
        (ack_take && !hi_reg) |=> !ple && !req_reg && svc_reg == PIRC_SVC_LOW;
    endproperty
    a_ack_low: assert property (p_ack_low) else $error("low response left enable set");

    // the return instruction reopens exactly the level that was closed
    property p_return_from_interrupt_instruction_low;
        @(posedge sys_clk) disable iff (!rstn)
        (core_return_from_interrupt_instruction && !ack_take && svc_reg == PIRC_SVC_LOW) |=> ple && svc_reg == PIRC_SVC_NONE;
    endproperty
    a_return_from_interrupt_instruction_low: assert property (p_return_from_interrupt_instruction_low) else $error("return did not reopen low");

    property p_return_from_interrupt_instruction_both;
        @(posedge sys_clk) disable iff (!rstn)
        (core_return_from_interrupt_instruction && !ack_take && svc_reg == PIRC_SVC_BOTH) |=> ghe && svc_reg == PIRC_SVC_LOW;
    endproperty
    a_return_from_interrupt_instruction_both: assert property (p_return_from_interrupt_instruction_both) else $error("nested return lost low service");

    // mode flips take one cycle to reach the registered level, hence the past term
    property p_compat_hi;
        @(posedge sys_clk) disable iff (!rstn)
        (!pme && !$past(pme) && req_reg) |-> hi_reg;
    endproperty
    a_compat_hi: assert property (p_compat_hi) else $error("compat request not high level");

    property p_periph_gate;
        @(posedge sys_clk) disable iff (!rstn)
        (!pme && !ple && ((fe & ~PERIPH_MASK[NSRC-1:0]) == '0)) |=> !req_reg;
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral passed closed gate");

    property p_compat_all;
        @(posedge sys_clk) disable iff (!rstn)
        (!pme && ghe && ple && (fe != '0) && !ack_take) |=> req_reg && vec_reg == PIRC_VEC_HIGH;
    endproperty
    a_compat_all: assert property (p_compat_all) else $error("compat source not vectored");

    property p_low_vec;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && ghe && ple && !svc_reg[1] && ((fe & prio_eff) == '0) && ((fe & ~prio_eff) != '0) && !ack_take)
        |=> req_reg && !hi_reg && vec_reg == PIRC_VEC_LOW;
    endproperty
    a_low_vec: assert property (p_low_vec) else $error("low request not vectored low");

    property p_high_no_low_en;
        @(posedge sys_clk) disable iff (!rstn)
        (pme && ghe && !ple && ((fe & prio_eff) != '0) && !ack_take) |=> req_reg && hi_reg && vec_reg == PIRC_VEC_HIGH;
    endproperty
    a_high_no_low_en: assert property (p_high_no_low_en) else $error("low enable blocked high");

    // a flag only falls by a software write; the response and the return leave it set
    property p_flag_hold;
        @(posedge sys_clk) disable iff (!rstn)
        (flag_reg[0] && !(reg_wr && reg_addr == PIRC_ADDR_FLAG)) |=> flag_reg[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag fell without write");

    property p_stat_ro;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == PIRC_ADDR_STAT && !ack_take && !core_return_from_interrupt_instruction) |=> $stable(svc_reg);
    endproperty
    a_stat_ro: assert property (p_stat_ro) else $error("status changed by write");

    property p_pme_on;
        @(posedge sys_clk) disable iff (!rstn)
        (reg_wr && reg_addr == PIRC_ADDR_RESET_CONTROL_REGISTER && reg_wdata[PIRC_BIT_PME]) |=> pme;
    endproperty
    a_pme_on: assert property (p_pme_on) else $error("priority mode not entered");

    c_nested: cover property (@(posedge sys_clk) disable iff (!rstn) svc_reg == PIRC_SVC_BOTH);
    c_low_ack: cover property (@(posedge sys_clk) disable iff (!rstn) ack_take && !hi_reg);
    c_compat_ack: cover property (@(posedge sys_clk) disable iff (!rstn) ack_take && !pme);
    c_ret_both: cover property (@(posedge sys_clk) disable iff (!rstn) core_return_from_interrupt_instruction && svc_reg == PIRC_SVC_BOTH);
    c_low_held: cover property (@(posedge sys_clk) disable iff (!rstn) pme && svc_reg[1] && ((fe & ~prio_eff) != '0));
endmodule : pirc_core

// ### sim/pirc_core_model.sv
// core-side partner: takes pending interrupts and runs the return instruction
// assumes it shares sys_clk and rstn with the controller
`timescale 1ns/10ps
module pirc_core_model (
    input  wire logic        sys_clk,     // core clock
    input  wire logic        rstn,        // async reset, active low
    input  wire logic        take_en,     // core accepts interrupts
    input  wire logic [3:0]  dly,         // cycles a request waits before taking
    input  wire logic        ret_cmd,     // run the return instruction
    input  wire logic        irq_req,     // pending request
    input  wire logic [15:0] irq_vector,  // branch address offered
    output logic             core_ack,    // take pulse
    output logic             core_return_from_interrupt_instruction, // return pulse
    output logic      [15:0] took_vec     // vector of the last take
);
    logic [3:0] cnt_reg;
    // a standing request is taken after dly cycles, so a slow core can be modelled
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg     <= 4'h0;
            core_ack    <= 1'b0;
            core_return_from_interrupt_instruction <= 1'b0;
            took_vec    <= 16'h0000;
        end else begin
            core_ack    <= 1'b0;
            core_return_from_interrupt_instruction <= ret_cmd;
            if (take_en && irq_req && !core_ack) begin
                cnt_reg <= (cnt_reg == dly) ? 4'h0 : cnt_reg + 4'h1;
                if (cnt_reg == dly) begin
                    core_ack <= 1'b1;          // branch taken only while requested
                    took_vec <= irq_vector;
                end
            end else begin
                cnt_reg <= 4'h0;
            end
        end
    end
endmodule : pirc_core_model

// ### sim/pirc_core_tb.sv
// self-checking bench for the interrupt controller: register port plus a core model
// assumes the package register map and one 20 MHz clock
`timescale 1ns/10ps
module pirc_core_tb import pirc_pkg::*;;
    logic        sys_clk, rstn, reg_wr, reg_rd, take_en, ret_cmd;
    logic        core_ack, core_return_from_interrupt_instruction, irq_req, irq_hi;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [39:0] src_event;
    logic [15:0] irq_vector, took_vec;
    logic [3:0]  dly;
    int          err_count, n_compared, cycles;

    pirc_core u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .core_ack(core_ack), .core_return_from_interrupt_instruction(core_return_from_interrupt_instruction), .irq_req(irq_req), .irq_hi(irq_hi),
        .irq_vector(irq_vector));
    pirc_core_model u_core (.sys_clk(sys_clk), .rstn(rstn), .take_en(take_en), .dly(dly),
        .ret_cmd(ret_cmd), .irq_req(irq_req), .irq_vector(irq_vector), .core_ack(core_ack),
        .core_return_from_interrupt_instruction(core_return_from_interrupt_instruction), .took_vec(took_vec));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : idle
    task automatic ev(input int i);
        @(posedge sys_clk);
        src_event <= 40'h1 << i;
        @(posedge sys_clk);
        src_event <= '0;
    endtask : ev
    task automatic irq_is(input logic r, input logic h, input logic [15:0] v);
        chk({15'h0000, irq_req}, {15'h0000, r});
        if (r) chk({irq_hi, irq_vector}, {h, v});
    endtask : irq_is
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // a hung sequence ends as a mismatch
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            $display("[FAIL] t=%0t timeout", $time);
            conclude();
        end
    end

    initial begin
        {rstn, reg_wr, reg_rd, take_en, ret_cmd} = '0;
        {reg_addr, reg_wdata, src_event, dly} = '0;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        for (int g = 0; g < PIRC_NGRP; g++) begin
            rd(PIRC_ADDR_FLAG + 8'(g), PIRC_RST_FLAG);
            rd(PIRC_ADDR_EN + 8'(g), PIRC_RST_EN);
            rd(PIRC_ADDR_PRIO + 8'(g), PIRC_RST_PRIO);
        end
        rd(PIRC_ADDR_CTL0, PIRC_RST_CTL);
        rd(PIRC_ADDR_RESET_CONTROL_REGISTER, PIRC_RST_RESET_CONTROL_REGISTER);
        wr(PIRC_ADDR_CTL2, 8'h5a);
        rd(PIRC_ADDR_CTL2, 8'h5a);
        wr(PIRC_ADDR_STAT, 8'hff);
        rd(PIRC_ADDR_STAT, 8'h00);
        rd(8'h20, 8'h00);
        $display("test registers done");
        // compatibility mode, peripheral source 8 marked low priority
        wr(PIRC_ADDR_EN + 8'h01, 8'h01);
        wr(PIRC_ADDR_PRIO + 8'h01, 8'h00);
        wr(PIRC_ADDR_CTL0, 8'h80);
        ev(8);
        idle(3);
        rd(PIRC_ADDR_FLAG + 8'h01, 8'h01);
        irq_is(1'b0, 1'b1, PIRC_VEC_HIGH);
        wr(PIRC_ADDR_CTL0, 8'hc0);
        idle(2);
        irq_is(1'b1, 1'b1, PIRC_VEC_HIGH);
        wr(PIRC_ADDR_EN + 8'h01, 8'h00);
        idle(2);
        irq_is(1'b0, 1'b1, PIRC_VEC_HIGH);
        wr(PIRC_ADDR_EN + 8'h01, 8'h01);
        wr(PIRC_ADDR_CTL0, 8'h40);
        idle(2);
        irq_is(1'b0, 1'b1, PIRC_VEC_HIGH);
        take_en <= 1'b1;
        dly     <= 4'h3;
        wr(PIRC_ADDR_CTL0, 8'hc0);
        idle(10);
        chk(took_vec, PIRC_VEC_HIGH);
        rd(PIRC_ADDR_CTL0, 8'h40);
        wr(PIRC_ADDR_FLAG + 8'h01, 8'h00);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        idle(3);
        rd(PIRC_ADDR_CTL0, 8'hc0);
        irq_is(1'b0, 1'b1, PIRC_VEC_HIGH);
        take_en <= 1'b0;
        $display("test compatibility done");
        // priority mode: source 0 forced high, source 1 low
        wr(PIRC_ADDR_EN + 8'h01, 8'h00);
        wr(PIRC_ADDR_RESET_CONTROL_REGISTER, 8'h80);
        wr(PIRC_ADDR_PRIO, 8'h00);
        wr(PIRC_ADDR_EN, 8'h03);
        wr(PIRC_ADDR_CTL0, 8'hc0);
        ev(1);
        idle(3);
        irq_is(1'b1, 1'b0, PIRC_VEC_LOW);
        wr(PIRC_ADDR_CTL0, 8'h80);
        idle(2);
        irq_is(1'b0, 1'b0, PIRC_VEC_LOW);
        ev(0);
        idle(3);
        irq_is(1'b1, 1'b1, PIRC_VEC_HIGH);
        wr(PIRC_ADDR_CTL0, 8'h40);
        idle(2);
        irq_is(1'b0, 1'b1, PIRC_VEC_HIGH);
        wr(PIRC_ADDR_FLAG, 8'h02);
        take_en <= 1'b1;
        dly     <= 4'h0;
        wr(PIRC_ADDR_CTL0, 8'hc0);
        idle(6);
        rd(PIRC_ADDR_STAT, 8'h01);
        chk(took_vec, PIRC_VEC_LOW);
        ev(0);
        idle(6);
        chk(took_vec, PIRC_VEC_HIGH);
        rd(PIRC_ADDR_STAT, 8'h03);
        $display("test priority done");
        // unwind the nested service: both, then low, then none
        take_en <= 1'b0;
        wr(PIRC_ADDR_FLAG, 8'h00);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        idle(3);
        rd(PIRC_ADDR_STAT, 8'h01);
        rd(PIRC_ADDR_CTL0, 8'h80);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
        idle(3);
        rd(PIRC_ADDR_STAT, 8'h00);
        rd(PIRC_ADDR_CTL0, 8'hc0);
        // reset again in mid-run: outputs and registers return to reset values
        @(posedge sys_clk);
        rstn <= 1'b0;
        idle(2);
        chk({irq_hi, irq_vector}, {1'b1, PIRC_VEC_HIGH});
        chk({15'h0000, irq_req}, 16'h0000);
        @(posedge sys_clk);
        rstn <= 1'b1;
        rd(PIRC_ADDR_RESET_CONTROL_REGISTER, PIRC_RST_RESET_CONTROL_REGISTER);
        rd(PIRC_ADDR_CTL0, PIRC_RST_CTL);
        $display("test return and reset done");
        conclude();
    end
endmodule : pirc_core_tb
